// *** design/spcr_core.v ***
// stepper phase counter, step modes, hold logic and pwm current regulation
// Operation
// R1 - enable low: standby, everything at default
// R2 - active only after startup time elapses
// R3 - cycle has 64/32/16/8/4 positions per mode
// R4 - phase changed by serial or step pin
// R5 - phase reaches references next pwm period
// R6 - step pin mode: serial read-only, mode step
// R7 - function 1: select pin picks alternate mode
// R8 - increments 1,2,4,16 for codes 0,1,3,4
// R9 - half step code 2 increments by 8
// R10 - automatic steps wrap modulo 64
// R11 - coarser mode snaps phase to nearest
// R12 - serial mode ignores step pin
// R13 - serial mode: step mode matters in full
// R14 - mode change applies after phase update
// R15 - 17-entry quarter sine times scale
// R16 - run scale, hold scale in hold
// R17 - phase gives signs and table entry
// R18 - full step: full scale both phases
// R19 - bridges on until reference, then decay
// R20 - pwm frequency select with wobble
// R21 - minimum on time blanking plus filter
// R22 - hold from serial or select pin
// R23 - stall count sets sticky hold request
// R24 - hold uses hold decay selection
// R25 - phase frozen while stall auto hold
// R26 - direction clear increments, set decrements
`include "spcr_defs.vh"
`default_nettype none
module spcr_core #(
  parameter integer START_CYC = `SPCR_T_START_US * `SPCR_CLK_MHZ
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // device pins
  input wire en_pin,
  input wire step_pulse_pin,
  input wire mode_select_pin,
  // current comparators, high when coil current reached reference
  input wire cmp_a,
  input wire cmp_b,
  // serial phase and hold writes
  input wire ph_wr,
  input wire [5:0] ph_wdata,
  input wire hold_wr,
  input wire hold_wdata,
  // configuration
  input wire step_pin_enable,
  input wire direction_bit,
  input wire [1:0] mode_pin_function,
  input wire [2:0] primary_step_mode,
  input wire [2:0] alternate_step_mode,
  input wire [3:0] run_current_scale,
  input wire [3:0] hold_current_scale,
  input wire [1:0] pwm_freq_select,
  input wire freq_wobble_enable,
  input wire [1:0] blank_time_sel,
  input wire [1:0] run_decay_select,
  input wire hold_decay_select,
  input wire stall_auto_hold_enable,
  input wire [2:0] stall_count_threshold,
  // stall detector
  input wire stall_sample,
  input wire stall_seen,
  input wire stall_flag_clr,
  // status
  output wire active,
  output wire [5:0] phase_count,
  output wire [2:0] applied_step_mode,
  output wire hold_request,
  output wire stall_detected_flag,
  // bridge control
  output wire pwm_start,
  output wire bridge_a_on,
  output wire bridge_b_on,
  output wire [1:0] decay_sel,
  output wire [9:0] ref_a,
  output wire [9:0] ref_b,
  output wire neg_a,
  output wire neg_b
);
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  function integer cyc_up(input integer ns);
    begin
      cyc_up = (ns * `SPCR_CLK_MHZ + 999) / 1000;
    end
  endfunction

  localparam integer FILT_CYC = cyc_up(`SPCR_T_FILT_NS);
  localparam integer BL0_CYC = cyc_up(`SPCR_T_BLANK0_NS) + FILT_CYC;
  localparam integer BL1_CYC = cyc_up(`SPCR_T_BLANK1_NS) + FILT_CYC;
  localparam integer BL2_CYC = cyc_up(`SPCR_T_BLANK2_NS) + FILT_CYC;
  localparam integer BL3_CYC = cyc_up(`SPCR_T_BLANK3_NS) + FILT_CYC;
  localparam integer PER0_CYC = `SPCR_CLK_HZ / `SPCR_PWM_F0_HZ;
  localparam integer PER1_CYC = `SPCR_CLK_HZ / `SPCR_PWM_F1_HZ;
  localparam integer PER2_CYC = `SPCR_CLK_HZ / `SPCR_PWM_F2_HZ;
  localparam integer PER3_CYC = `SPCR_CLK_HZ / `SPCR_PWM_F3_HZ;
  localparam integer START_LAST_I = START_CYC - 1;
  localparam [15:0] START_LAST = START_LAST_I[15:0];

  function [11:0] min_on(input [1:0] sel);
    begin
      case (sel)
        2'h0: min_on = BL0_CYC[11:0];
        2'h1: min_on = BL1_CYC[11:0];
        2'h2: min_on = BL2_CYC[11:0];
        default: min_on = BL3_CYC[11:0];
      endcase
    end
  endfunction

  function [11:0] per_len(input [1:0] sel);
    begin
      case (sel)
        2'h0: per_len = PER0_CYC[11:0];
        2'h1: per_len = PER1_CYC[11:0];
        2'h2: per_len = PER2_CYC[11:0];
        default: per_len = PER3_CYC[11:0];
      endcase
    end
  endfunction

  // R8 R9 step increments
  function [5:0] step_inc(input [2:0] m);
    begin
      case (m)
        `SPCR_SM_16: step_inc = `SPCR_INC_16;
        `SPCR_SM_8: step_inc = `SPCR_INC_8;
        `SPCR_SM_HALF: step_inc = `SPCR_INC_HALF;
        `SPCR_SM_MINI: step_inc = `SPCR_INC_MINI;
        `SPCR_SM_FULL: step_inc = `SPCR_INC_FULL;
        default: step_inc = `SPCR_INC_16;
      endcase
    end
  endfunction

  // round to nearest multiple of inc, ties upward, modulo 64
  function [5:0] snap(input [5:0] p, input [5:0] inc);
    begin
      snap = (p + {1'b0, inc[5:1]}) & ~(inc - `SPCR_INC_16);
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg [`SPCR_NPINS-1:0] s1_q, s2_q, s3_q, pin_q;
  wire [`SPCR_NPINS-1:0] pins_raw = {cmp_b, cmp_a, mode_select_pin, step_pulse_pin, en_pin};
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= {`SPCR_NPINS{1'b0}};
      s2_q <= {`SPCR_NPINS{1'b0}};
      s3_q <= {`SPCR_NPINS{1'b0}};
      pin_q <= {`SPCR_NPINS{1'b0}};
    end else begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // a level counts once second and third stages agree
      pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
    end
  end
  wire en_f = pin_q[`SPCR_PIN_EN];
  wire msel_f = pin_q[`SPCR_PIN_MSEL];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  reg active_q, step_d_q, pend_q, hold_reg_q, hold_q, sdf_q, wob_dn_q;
  reg start_q, on_a_q, on_b_q, neg_a_q, neg_b_q;
  reg [15:0] start_cnt_q;
  reg [5:0] ph_q;
  reg [2:0] mode_q, stall_cnt_q;
  reg [11:0] per_cnt_q, mon_q;
  reg [3:0] wob_q;
  reg [1:0] decay_q;
  reg [9:0] ref_a_q, ref_b_q;

  // ---------------------------------------------------------------
  // step mode, phase update and snapping
  // ---------------------------------------------------------------
  // R7 select pin picks mode
  wire [2:0] act_mode = (mode_pin_function == `SPCR_MPF_SMODE && msel_f) ?
                        alternate_step_mode : primary_step_mode;
  // R25 freeze on stall hold
  wire freeze = sdf_q & stall_auto_hold_enable;
  wire step_rise = pin_q[`SPCR_PIN_STEP] & ~step_d_q;
  // R4 exclusive phase source
  // R12 step pin ignored serially
  wire step_ev = active_q & step_pin_enable & step_rise & ~freeze;
  // R6 serial write ignored here
  wire wr_ev = active_q & ~step_pin_enable & ph_wr & ~freeze;
  wire [5:0] inc_cur = step_inc(mode_q);
  // R26 direction sets sign
  // R10 wrap modulo 64
  wire [5:0] ph_step = direction_bit ? ph_q - inc_cur : ph_q + inc_cur;
  wire [5:0] ph_mod = step_ev ? ph_step : (wr_ev ? ph_wdata : ph_q);
  wire upd = pend_q | step_ev | wr_ev;
  wire pstart = active_q && per_cnt_q == 12'h000;
  // R14 mode taken after update
  wire [2:0] mode_new = upd ? act_mode : mode_q;
  wire [5:0] inc_new = step_inc(mode_new);
  // R11 snap on coarser mode
  wire coarser = step_pin_enable && inc_new > inc_cur;
  wire [5:0] ph_app = (pstart && upd && coarser && !freeze) ? snap(ph_mod, inc_new) : ph_mod;

  // ---------------------------------------------------------------
  // hold and stall
  // ---------------------------------------------------------------
  wire [3:0] cnt_nx = {1'b0, stall_cnt_q} + 4'h1;
  wire stall_hit = stall_sample & stall_seen & (cnt_nx >= {1'b0, stall_count_threshold});
  // R22 hold source select
  wire hold_src = (mode_pin_function == `SPCR_MPF_HOLD) ? msel_f : hold_reg_q;
  // R23 stall lock keeps hold
  wire hold_nx = active_q & (freeze | hold_src);

  // ---------------------------------------------------------------
  // current references
  // ---------------------------------------------------------------
  wire [9:0] cr_a, cr_b;
  wire cr_na, cr_nb;
  // R16 hold scale substitution
  wire [3:0] scale = hold_nx ? hold_current_scale : run_current_scale;
  // R13 serial mode uses mode only for full
  spcr_cur_ref u_ref (
    .ph(ph_app),
    .full_step(mode_new == `SPCR_SM_FULL),
    .scale(scale),
    .ref_a(cr_a),
    .ref_b(cr_b),
    .neg_a(cr_na),
    .neg_b(cr_nb)
  );

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {active_q, step_d_q, pend_q, hold_reg_q, hold_q, sdf_q, wob_dn_q} <= 7'h00;
      {start_q, on_a_q, on_b_q, neg_a_q, neg_b_q} <= 5'h00;
      start_cnt_q <= 16'h0000;
      ph_q <= `SPCR_PH_RST;
      mode_q <= `SPCR_SM_16;
      stall_cnt_q <= 3'h0;
      per_cnt_q <= 12'h000;
      mon_q <= 12'h000;
      wob_q <= 4'h0;
      decay_q <= 2'h0;
      ref_a_q <= 10'h000;
      ref_b_q <= 10'h000;
    end else if (!en_f) begin
      // R1 standby defaults
      {active_q, step_d_q, pend_q, hold_reg_q, hold_q, sdf_q, wob_dn_q} <= 7'h00;
      {start_q, on_a_q, on_b_q, neg_a_q, neg_b_q} <= 5'h00;
      start_cnt_q <= 16'h0000;
      ph_q <= `SPCR_PH_RST;
      mode_q <= `SPCR_SM_16;
      stall_cnt_q <= 3'h0;
      per_cnt_q <= 12'h000;
      mon_q <= 12'h000;
      wob_q <= 4'h0;
      decay_q <= 2'h0;
      ref_a_q <= 10'h000;
      ref_b_q <= 10'h000;
    end else begin
      // R2 startup delay
      if (!active_q) begin
        if (start_cnt_q == START_LAST) begin
          active_q <= 1'b1;
        end else begin
          start_cnt_q <= start_cnt_q + 16'h0001;
        end
      end
      step_d_q <= pin_q[`SPCR_PIN_STEP];
      // R5 apply at period start
      ph_q <= ph_app;
      if (pstart && upd) begin
        mode_q <= mode_new;
        pend_q <= 1'b0;
      end else begin
        pend_q <= upd;
      end
      // stall counting and sticky flag, set wins over clear
      if (stall_sample) begin
        stall_cnt_q <= (stall_seen && !stall_hit) ? cnt_nx[2:0] : 3'h0;
      end
      sdf_q <= active_q & (stall_hit | (sdf_q & ~stall_flag_clr));
      if (active_q && stall_hit && stall_auto_hold_enable) begin
        hold_reg_q <= 1'b1;
      end else if (active_q && hold_wr && !freeze &&
                   mode_pin_function != `SPCR_MPF_HOLD) begin
        hold_reg_q <= hold_wdata;
      end
      hold_q <= hold_nx;
      // R20 period and wobble
      start_q <= pstart;
      if (pstart) begin
        per_cnt_q <= per_len(pwm_freq_select) + {8'h00, wob_q};
        if (!freq_wobble_enable) begin
          wob_q <= 4'h0;
          wob_dn_q <= 1'b0;
        end else if (wob_dn_q) begin
          wob_q <= wob_q - 4'h1;
          wob_dn_q <= (wob_q != 4'h1);
        end else begin
          wob_q <= wob_q + 4'h1;
          wob_dn_q <= (wob_q == `SPCR_WOB_MAX - 4'h1);
        end
      end else if (active_q) begin
        per_cnt_q <= per_cnt_q - 12'h001;
      end
      // R19 on phase then decay
      if (pstart) begin
        on_a_q <= 1'b1;
        on_b_q <= 1'b1;
        // R21 minimum on time
        mon_q <= min_on(blank_time_sel);
        ref_a_q <= cr_a;
        ref_b_q <= cr_b;
        neg_a_q <= cr_na;
        neg_b_q <= cr_nb;
        // R24 hold decay
        decay_q <= hold_nx ? (hold_decay_select ? `SPCR_DEC_MIXED : `SPCR_DEC_SLOW) :
                   run_decay_select;
      end else if (mon_q != 12'h000) begin
        mon_q <= mon_q - 12'h001;
      end else begin
        if (pin_q[`SPCR_PIN_CMPA]) begin
          on_a_q <= 1'b0;
        end
        if (pin_q[`SPCR_PIN_CMPB]) begin
          on_b_q <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign active = active_q;
  // R3 positions per mode
  assign phase_count = ph_q;
  assign applied_step_mode = mode_q;
  assign hold_request = hold_q;
  assign stall_detected_flag = sdf_q;
  assign pwm_start = start_q;
  assign bridge_a_on = on_a_q;
  assign bridge_b_on = on_b_q;
  assign decay_sel = decay_q;
  assign ref_a = ref_a_q;
  assign ref_b = ref_b_q;
  assign neg_a = neg_a_q;
  assign neg_b = neg_b_q;
endmodule // spcr_core
`default_nettype wire

// *** design/spcr_defs.vh ***
// constants for the stepper phase counter and current reference block
`ifndef SPCR_DEFS_VH
`define SPCR_DEFS_VH
// ---------------------------------------------------------------
// clock and times
// ---------------------------------------------------------------
`define SPCR_CLK_MHZ 50
`define SPCR_CLK_HZ 50000000
`define SPCR_T_START_US 200
`define SPCR_T_FILT_NS 500
`define SPCR_T_BLANK0_NS 500
`define SPCR_T_BLANK1_NS 1000
`define SPCR_T_BLANK2_NS 1500
`define SPCR_T_BLANK3_NS 2000
`define SPCR_PWM_F0_HZ 15625
`define SPCR_PWM_F1_HZ 20000
`define SPCR_PWM_F2_HZ 31250
`define SPCR_PWM_F3_HZ 40000
`define SPCR_WOB_MAX 4'hF
// ---------------------------------------------------------------
// pin synchroniser bit positions
// ---------------------------------------------------------------
`define SPCR_PIN_EN 0
`define SPCR_PIN_STEP 1
`define SPCR_PIN_MSEL 2
`define SPCR_PIN_CMPA 3
`define SPCR_PIN_CMPB 4
`define SPCR_NPINS 5
// ---------------------------------------------------------------
// step mode codes and increments
// ---------------------------------------------------------------
`define SPCR_SM_16 3'h0
`define SPCR_SM_8 3'h1
`define SPCR_SM_HALF 3'h2
`define SPCR_SM_MINI 3'h3
`define SPCR_SM_FULL 3'h4
`define SPCR_INC_16 6'h01
`define SPCR_INC_8 6'h02
`define SPCR_INC_MINI 6'h04
`define SPCR_INC_HALF 6'h08
`define SPCR_INC_FULL 6'h10
// ---------------------------------------------------------------
// pin functions, decay codes, table
// ---------------------------------------------------------------
`define SPCR_MPF_SMODE 2'h1
`define SPCR_MPF_HOLD 2'h2
`define SPCR_DEC_SLOW 2'h1
`define SPCR_DEC_MIXED 2'h2
`define SPCR_QTR 5'h10
`define SPCR_FULL_MAG 6'h3F
`define SPCR_PH_RST 6'h00
`endif

// *** design/spcr_cur_ref.v ***
// quarter-sine lookup and scaling into the two coil current references
`default_nettype none
module spcr_cur_ref (
  // phase and mode
  input wire [5:0] ph,
  input wire full_step,
  input wire [3:0] scale,
  // references
  output wire [9:0] ref_a,
  output wire [9:0] ref_b,
  output wire neg_a,
  output wire neg_b
);
  // ---------------------------------------------------------------
  // table
  // ---------------------------------------------------------------
  function [5:0] sine_mag(input [4:0] idx);
    begin
      case (idx)
        5'h00: sine_mag = 6'h00;
        5'h01: sine_mag = 6'h06;
        5'h02: sine_mag = 6'h0C;
        5'h03: sine_mag = 6'h12;
        5'h04: sine_mag = 6'h18;
        5'h05: sine_mag = 6'h1E;
        5'h06: sine_mag = 6'h23;
        5'h07: sine_mag = 6'h28;
        5'h08: sine_mag = 6'h2D;
        5'h09: sine_mag = 6'h31;
        5'h0A: sine_mag = 6'h34;
        5'h0B: sine_mag = 6'h38;
        5'h0C: sine_mag = 6'h3A;
        5'h0D: sine_mag = 6'h3C;
        5'h0E: sine_mag = 6'h3E;
        default: sine_mag = 6'h3F;
      endcase
    end
  endfunction

  function [9:0] scaled(input [5:0] mag, input [3:0] s);
    begin
      scaled = {4'h0, mag} * {6'h00, s};
    end
  endfunction

  wire [4:0] idx_lo = {1'b0, ph[3:0]};
  wire [4:0] idx_hi = `SPCR_QTR - idx_lo;
  // R17 sign and entry
  wire [4:0] idx_b = ph[4] ? idx_hi : idx_lo;
  wire [4:0] idx_a = ph[4] ? idx_lo : idx_hi;
  // R18 full step bypass
  wire [5:0] mag_a = full_step ? `SPCR_FULL_MAG : sine_mag(idx_a);
  wire [5:0] mag_b = full_step ? `SPCR_FULL_MAG : sine_mag(idx_b);
  // R15 scale table value
  assign ref_a = scaled(mag_a, scale);
  assign ref_b = scaled(mag_b, scale);
  assign neg_b = ph[5];
  assign neg_a = ph[5] ^ ph[4];
endmodule // spcr_cur_ref
`default_nettype wire

// *** testbench/spcr_core_sva.sv ***
// assertion checker for the stepper phase counter core
`default_nettype none
module spcr_core_sva #(
  parameter integer START_CYC = 10000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // inputs watched
  input wire logic en_pin,
  input wire logic ph_wr,
  input wire logic [5:0] ph_wdata,
  input wire logic step_pin_enable,
  input wire logic [1:0] blank_time_sel,
  input wire logic [1:0] run_decay_select,
  input wire logic hold_decay_select,
  input wire logic [3:0] run_current_scale,
  input wire logic [3:0] hold_current_scale,
  input wire logic stall_auto_hold_enable,
  // outputs watched
  input wire logic active,
  input wire logic [5:0] phase_count,
  input wire logic [2:0] applied_step_mode,
  input wire logic hold_request,
  input wire logic stall_detected_flag,
  input wire logic pwm_start,
  input wire logic bridge_a_on,
  input wire logic bridge_b_on,
  input wire logic [1:0] decay_sel,
  input wire logic [9:0] ref_a,
  input wire logic [9:0] ref_b
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic [31:0] en_q;
  logic [7:0] on_q;
  logic [7:0] min_on;
  logic frz;
  assign min_on = 8'h19 * ({6'h00, blank_time_sel} + 8'h01) + 8'h19;
  assign frz = stall_detected_flag && stall_auto_hold_enable;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      en_q <= 32'h0;
      on_q <= 8'h00;
    end else begin
      en_q <= en_pin ? en_q + 32'h1 : 32'h0;
      on_q <= !bridge_a_on ? 8'h00 : (on_q == 8'hFF ? on_q : on_q + 8'h01);
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_standby_defaults: assert property (
    !en_pin [*6] |-> !active && phase_count == 6'h00 && !hold_request && !stall_detected_flag)
    else $error("standby state not at defaults");
  a_startup_delay: assert property ($rose(active) |-> en_q >= START_CYC)
    else $error("active rose before startup time");
  a_serial_write: assert property (
    ph_wr && active && !step_pin_enable && !frz ##1 active |-> phase_count == $past(ph_wdata))
    else $error("serial phase write not taken");
  a_pin_ignored: assert property (
    active && !step_pin_enable && !ph_wr ##1 active |-> $stable(phase_count))
    else $error("phase moved without serial write");
  a_stall_freeze: assert property (active && frz ##1 active |-> $stable(phase_count))
    else $error("phase moved while frozen");
  a_stall_hold: assert property (active && frz ##1 active |-> hold_request)
    else $error("stall auto hold not set");
  a_period_bridges: assert property (pwm_start |-> bridge_a_on && bridge_b_on)
    else $error("bridges not on at period start");
  a_bridge_rise: assert property ($rose(bridge_b_on) |-> pwm_start)
    else $error("bridge rose outside period start");
  a_min_on: assert property ($fell(bridge_a_on) && active |-> on_q >= min_on - 8'h01)
    else $error("bridge on time below minimum");
  a_full_ref: assert property (
    pwm_start && applied_step_mode == 3'h4 && $stable(hold_request) |-> ref_a == ref_b
    && ref_a == 10'h03F * {6'h00, hold_request ? $past(hold_current_scale) :
    $past(run_current_scale)})
    else $error("full step reference wrong");
  a_decay_pick: assert property (pwm_start && $stable(hold_request) |-> decay_sel ==
    (hold_request ? ($past(hold_decay_select) ? 2'h2 : 2'h1) : $past(run_decay_select)))
    else $error("decay selection wrong");
  c_write: cover property (ph_wr && active && !step_pin_enable);
  c_full: cover property (pwm_start && applied_step_mode == 3'h4);
  c_hold: cover property ($rose(hold_request));
  c_stall: cover property ($rose(stall_detected_flag));
endmodule // spcr_core_sva

bind spcr_core spcr_core_sva #(.START_CYC(START_CYC)) i_sva (.*);
`default_nettype wire

// *** testbench/spcr_host_model.sv ***
// host model: serial phase and hold writes, direct control pins
`default_nettype none
module spcr_host_model (
  // clock
  input wire logic clk,
  // pins and serial writes
  output var logic step_pulse_pin,
  output var logic mode_select_pin,
  output var logic ph_wr,
  output var logic [5:0] ph_wdata,
  output var logic hold_wr,
  output var logic hold_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    step_pulse_pin = 1'b0;
    mode_select_pin = 1'b0;
    ph_wr = 1'b0;
    ph_wdata = 6'h2D;
    hold_wr = 1'b0;
    hold_wdata = 1'b1;
  end
  task automatic wr_phase(input logic [5:0] d);
    @(negedge clk);
    ph_wr = 1'b1;
    ph_wdata = d;
    @(negedge clk);
    ph_wr = 1'b0;
    ph_wdata = ~d;
  endtask
  task automatic wr_hold(input logic d);
    @(negedge clk);
    hold_wr = 1'b1;
    hold_wdata = d;
    @(negedge clk);
    hold_wr = 1'b0;
    hold_wdata = ~d;
    @(negedge clk);
  endtask
  // step pulse, each level held 5 clocks
  task automatic step_pin;
    repeat (5) @(negedge clk);
    step_pulse_pin = 1'b1;
    repeat (5) @(negedge clk);
    step_pulse_pin = 1'b0;
    repeat (5) @(negedge clk);
  endtask
  task automatic set_sel(input logic v);
    @(negedge clk);
    mode_select_pin = v;
    repeat (8) @(negedge clk);
  endtask
endmodule // spcr_host_model
`default_nettype wire

// *** testbench/spcr_core_tb.sv ***
// self-checking testbench for the stepper phase counter core
`default_nettype none
module spcr_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int START = 8;
  logic clk, rstn, en_pin, cmp_a, cmp_b, step_pin_enable, direction_bit, freq_wobble_enable;
  logic hold_decay_select, stall_auto_hold_enable, stall_sample, stall_seen, stall_flag_clr;
  logic step_pulse_pin, mode_select_pin, ph_wr, hold_wr, hold_wdata;
  logic [5:0] ph_wdata, phase_count, ex, pinc;
  logic [1:0] mode_pin_function, pwm_freq_select, blank_time_sel, run_decay_select, decay_sel;
  logic [2:0] primary_step_mode, alternate_step_mode, stall_count_threshold, applied_step_mode;
  logic [3:0] run_current_scale, hold_current_scale;
  logic active, hold_request, stall_detected_flag, pwm_start, bridge_a_on, bridge_b_on;
  logic neg_a, neg_b;
  logic [9:0] ref_a, ref_b;
  logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h4};
  logic [5:0] incs [5] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10};
  int n_fail = 0;
  int cmp_count = 0;
  spcr_core #(.START_CYC(START)) i_dut (.*);
  spcr_host_model i_host (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    $display("checks %0d errors %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic wait_ps;
    int i;
    i = 0;
    @(negedge clk);
    while (pwm_start !== 1'b1 && i < 1700) begin
      @(negedge clk);
      i++;
    end
    if (i == 1700) begin
      n_fail++;
      end_of_test();
    end
  endtask
  task automatic stall(input logic s);
    @(negedge clk);
    stall_seen = s;
    stall_sample = 1'b1;
    @(negedge clk);
    stall_sample = 1'b0;
    stall_seen = ~s;
  endtask
  function automatic logic [5:0] snap(input logic [5:0] p, input logic [5:0] inc);
    return (p + (inc >> 1)) & ~(inc - 6'h01);
  endfunction
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    rstn = 1'b0;
    en_pin = 1'b0;
    {cmp_a, cmp_b} = 2'h3;
    {step_pin_enable, direction_bit, freq_wobble_enable, hold_decay_select} = 4'h3;
    {stall_auto_hold_enable, stall_sample, stall_seen, stall_flag_clr} = 4'h2;
    {mode_pin_function, primary_step_mode, alternate_step_mode} = 8'h00;
    {pwm_freq_select, blank_time_sel, run_decay_select} = 6'h36;
    {run_current_scale, hold_current_scale, stall_count_threshold} = 11'h4CB;
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    chk("standby active", active, 1'b0);
    en_pin = 1'b1;
    n = 0;
    while (active !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n == 100) begin
      n_fail++;
      end_of_test();
    end
    chk("startup wait", n >= START, 1'b1);
    i_host.wr_phase(6'h2A);
    chk("serial phase", phase_count, 6'h2A);
    i_host.step_pin();
    chk("pin ignored", phase_count, 6'h2A);
    i_host.wr_phase(6'h00);
    wait_ps();
    wait_ps();
    chk("sign a", neg_a, 1'b0);
    i_host.wr_phase(6'h20);
    chk("sign b held", neg_b, 1'b0);
    wait_ps();
    chk("sign a", neg_a, 1'b1);
    chk("sign b", neg_b, 1'b1);
    i_host.wr_phase(6'h3B);
    wait_ps();
    step_pin_enable = 1'b1;
    mode_pin_function = 2'h1;
    ex = 6'h3B;
    pinc = 6'h01;
    for (int k = 0; k < 5; k++) begin
      if (k % 2) alternate_step_mode = codes[k];
      else primary_step_mode = codes[k];
      i_host.set_sel(k[0]);
      i_host.step_pin();
      ex = ex + pinc;
      wait_ps();
      if (incs[k] > pinc) ex = snap(ex, incs[k]);
      repeat (2) @(negedge clk);
      chk("applied mode", applied_step_mode, codes[k]);
      chk("phase snap", phase_count, ex);
      i_host.step_pin();
      ex = ex + incs[k];
      chk("phase up", phase_count, ex);
      direction_bit = 1'b1;
      i_host.step_pin();
      ex = ex - incs[k];
      chk("phase down", phase_count, ex);
      direction_bit = 1'b0;
      wait_ps();
      pinc = incs[k];
    end
    i_host.wr_phase(6'h01);
    chk("write refused", phase_count, ex);
    mode_pin_function = 2'h0;
    {run_current_scale, hold_current_scale, run_decay_select, hold_decay_select} = 11'h293;
    {freq_wobble_enable, pwm_freq_select, cmp_a, cmp_b} = 5'h09;
    i_host.wr_hold(1'b1);
    chk("hold serial", hold_request, 1'b1);
    wait_ps();
    wait_ps();
    chk("hold ref", ref_a, 10'h07E);
    chk("hold decay", decay_sel, 2'h2);
    i_host.wr_hold(1'b0);
    chk("hold off", hold_request, 1'b0);
    wait_ps();
    wait_ps();
    chk("run ref", ref_a, 10'h13B);
    chk("run decay", decay_sel, 2'h1);
    repeat (100) @(negedge clk);
    chk("bridges", {bridge_a_on, bridge_b_on}, 2'h2);
    mode_pin_function = 2'h2;
    i_host.set_sel(1'b1);
    chk("hold pin", hold_request, 1'b1);
    i_host.set_sel(1'b0);
    chk("hold pin off", hold_request, 1'b0);
    mode_pin_function = 2'h0;
    stall_auto_hold_enable = 1'b1;
    stall(1'b1);
    stall(1'b1);
    repeat (2) @(negedge clk);
    chk("stall early", stall_detected_flag, 1'b0);
    stall(1'b1);
    repeat (2) @(negedge clk);
    chk("stall flag", stall_detected_flag, 1'b1);
    chk("auto hold", hold_request, 1'b1);
    step_pin_enable = 1'b0;
    i_host.wr_phase(6'h15);
    chk("frozen", phase_count, ex);
    i_host.wr_hold(1'b0);
    chk("hold sticky", hold_request, 1'b1);
    stall_flag_clr = 1'b1;
    @(negedge clk);
    stall_flag_clr = 1'b0;
    i_host.wr_hold(1'b0);
    repeat (2) @(negedge clk);
    chk("hold cleared", hold_request, 1'b0);
    i_host.wr_phase(6'h15);
    chk("unfrozen", phase_count, 6'h15);
    en_pin = 1'b0;
    repeat (8) @(negedge clk);
    chk("standby", {active, phase_count}, 7'h00);
    end_of_test();
  end
endmodule // spcr_core_tb
`default_nettype wire
